// file: hw/rtm_cfg.svh
// Offsets, codes, reset values and timing counts of the radio test mode control block.
`ifndef RTM_CFG_SVH
`define RTM_CFG_SVH
`define RTM_OFS_TEST_SEL       8'h7e
`define RTM_OFS_TEST_CH        8'h7f
`define RTM_CODE_SINGLE        8'h63
`define RTM_CODE_SWEEP         8'h73
`define RTM_CH_DIR_BIT         7
`define RTM_CH_NUM_MSB         6
`define RTM_SWEEP_LAST_CH      7'h50
`define RTM_PWR_0DBM           2'h3
`define RTM_REG_RST            8'h00
`define RTM_DWELL_US           1000
`define RTM_CLK_MHZ            25
`define RTM_DWELL_CYC          (`RTM_DWELL_US * `RTM_CLK_MHZ)
`endif

// file: hw/rtm_pkg.sv
// Types shared by the radio test mode control block.
package rtm_pkg;
  typedef enum logic [1:0] {
    RTM_ST_NORMAL = 2'h0,
    RTM_ST_ENTER  = 2'h1,
    RTM_ST_TEST   = 2'h3
  } rtm_state_t;
  typedef logic [7:0] rtm_byte_t;
endpackage : rtm_pkg

// file: hw/rtm_test_ctrl.sv
// Test mode entry, latching and channel control for the audio transceiver.
`timescale 1ns/1ps
`include "rtm_cfg.svh"
// Functional notes
// R1: Write test registers, then force reconfig starts test.
// R2: Test mode held until reset only.
// R3: Test registers reachable via slave port when enabled.
// R4: EEPROM bit six set removes receiver slave port.
// R5: EEPROM data held low aborts load, slave enabled.
// R6: Code 0x63 selects single-channel test.
// R7: Code 0x73 sweeps 2400 to 2480 MHz.
// R8: Channel register bit seven: one transmit, zero receive.
// R9: Bits six to zero give channel offset.
// R10: Test mode forces 0 dBm output power.
// R11: Without EEPROM the receiver slave port stays enabled.
module rtm_test_ctrl #(
  parameter int DWELL_CYC = `RTM_DWELL_CYC
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Role strap and EEPROM loader
  input  wire logic             role_receiver,
  input  wire logic             eeprom_load_active,
  input  wire logic             eeprom_load_done,
  input  wire logic             eeprom_slave_disable,
  input  wire logic             eeprom_dout,
  // Register writes from the serial slave port
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_addr,
  input  wire rtm_pkg::rtm_byte_t reg_wdata,
  input  wire logic             force_reconfig,
  // Power setting in normal operation
  input  wire logic [1:0]       transmit_power_setting,
  // Radio control outputs
  output logic                  slave_if_en,
  output logic                  restart_pulse,
  output logic                  test_active,
  output logic                  test_sweep,
  output logic                  test_tx,
  output logic [6:0]            rf_channel,
  output logic [1:0]            rf_power_sel
);
  import rtm_pkg::*;

  rtm_state_t  state_r;
  rtm_state_t  state_nxt;
  rtm_byte_t   test_mode_select_r;
  rtm_byte_t   test_channel_direction_r;
  logic        role_meta_r;
  logic        role_sync_r;
  logic        dout_meta_r;
  logic        dout_sync_r;
  logic        load_abort_r;
  logic        slave_disable_r;
  logic [31:0] dwell_r;
  logic        wr_ok;

  function automatic logic code_valid(input rtm_byte_t code);
    code_valid = (code == `RTM_CODE_SINGLE) || (code == `RTM_CODE_SWEEP);
  endfunction : code_valid

  // Both the strap and the EEPROM data line are pins, hence two stages each.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      role_meta_r <= 1'b0;
      role_sync_r <= 1'b0;
      dout_meta_r <= 1'b1;
      dout_sync_r <= 1'b1;
    end else begin
      role_meta_r <= role_receiver;
      role_sync_r <= role_meta_r;
      dout_meta_r <= eeprom_dout;
      dout_sync_r <= dout_meta_r;
    end
  end

  // A low data line during the load aborts it, so the disable bit is never taken.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      load_abort_r    <= 1'b0;
      slave_disable_r <= 1'b0; // [R11]
    end else begin
      if (eeprom_load_active && !dout_sync_r) begin
        load_abort_r <= 1'b1; // [R5]
      end
      if (eeprom_load_done && !load_abort_r && !(eeprom_load_active && !dout_sync_r)) begin
        slave_disable_r <= eeprom_slave_disable; // [R4] [R11]
      end
    end
  end

  assign wr_ok = reg_wr && (!role_sync_r || !slave_disable_r); // [R3] [R4]

  always_ff @(posedge clk) begin
    if (!nrst) begin
      slave_if_en <= 1'b1;
    end else begin
      slave_if_en <= !role_sync_r || !slave_disable_r; // [R3] [R4]
    end
  end

  // Writes still land during test mode but never take effect: entry settings are frozen and reset clears both registers.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      test_mode_select_r       <= `RTM_REG_RST;
      test_channel_direction_r <= `RTM_REG_RST;
    end else if (wr_ok) begin
      if (reg_addr == `RTM_OFS_TEST_SEL) begin
        test_mode_select_r <= reg_wdata; // [R3]
      end
      if (reg_addr == `RTM_OFS_TEST_CH) begin
        test_channel_direction_r <= reg_wdata; // [R3]
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RTM_ST_NORMAL: begin
        if (force_reconfig && code_valid(test_mode_select_r)) begin
          state_nxt = RTM_ST_ENTER; // [R1]
        end
      end
      RTM_ST_ENTER: state_nxt = RTM_ST_TEST;
      RTM_ST_TEST:  state_nxt = RTM_ST_TEST; // [R2]
      default:      state_nxt = RTM_ST_NORMAL;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= RTM_ST_NORMAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Settings are frozen at entry so later register writes cannot disturb the radio.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      restart_pulse <= 1'b0;
      test_active   <= 1'b0;
      test_sweep    <= 1'b0;
      test_tx       <= 1'b0;
    end else begin
      restart_pulse <= (state_r == RTM_ST_NORMAL) && (state_nxt == RTM_ST_ENTER); // [R1]
      if (state_r == RTM_ST_ENTER) begin
        test_active <= 1'b1; // [R1] [R2]
        test_sweep  <= (test_mode_select_r == `RTM_CODE_SWEEP); // [R6] [R7]
        test_tx     <= test_channel_direction_r[`RTM_CH_DIR_BIT]; // [R8]
      end
    end
  end

  // Sweep dwells a fixed time on each 1 MHz step and wraps after 2480 MHz.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rf_channel <= 7'h00;
      dwell_r    <= 32'h0;
    end else if (state_r == RTM_ST_ENTER) begin
      dwell_r <= 32'h0;
      if (test_mode_select_r == `RTM_CODE_SWEEP) begin
        rf_channel <= 7'h00; // [R7]
      end else begin
        rf_channel <= test_channel_direction_r[`RTM_CH_NUM_MSB:0]; // [R9]
      end
    end else if (test_active && test_sweep) begin
      if (dwell_r == 32'(DWELL_CYC - 1)) begin
        dwell_r    <= 32'h0;
        rf_channel <= (rf_channel == `RTM_SWEEP_LAST_CH) ? 7'h00 : rf_channel + 7'h01; // [R7]
      end else begin
        dwell_r <= dwell_r + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rf_power_sel <= 2'h0;
    end else begin
      rf_power_sel <= (state_nxt != RTM_ST_NORMAL) ? `RTM_PWR_0DBM : transmit_power_setting; // [R10]
    end
  end

  a_entry_restart: assert property (@(posedge clk) disable iff (!nrst) // [R1]
    restart_pulse |=> test_active) else $error("test mode not entered after restart");
  a_test_sticky: assert property (@(posedge clk) disable iff (!nrst) // [R2]
    test_active |=> test_active) else $error("test mode left without reset");
  a_no_bad_entry: assert property (@(posedge clk) disable iff (!nrst) // [R1]
    $rose(restart_pulse) |-> $past(code_valid(test_mode_select_r))) else $error("entry without valid code");
  a_slave_gate: assert property (@(posedge clk) disable iff (!nrst) // [R4]
    (role_sync_r && slave_disable_r) |=> !slave_if_en) else $error("slave port alive when disabled");
  a_abort_keeps: assert property (@(posedge clk) disable iff (!nrst) // [R5]
    load_abort_r |-> !slave_disable_r) else $error("aborted load disabled slave port");
  a_single_chan: assert property (@(posedge clk) disable iff (!nrst) // [R9]
    (state_r == RTM_ST_ENTER && test_mode_select_r == `RTM_CODE_SINGLE) |=>
    (rf_channel == $past(test_channel_direction_r[6:0]) && !test_sweep)) else $error("wrong single channel");
  a_dir_bit: assert property (@(posedge clk) disable iff (!nrst) // [R8]
    state_r == RTM_ST_ENTER |=> test_tx == $past(test_channel_direction_r[7])) else $error("wrong direction");
  a_power_fixed: assert property (@(posedge clk) disable iff (!nrst) // [R10]
    test_active |-> rf_power_sel == `RTM_PWR_0DBM) else $error("power not 0 dBm in test");
  a_sweep_range: assert property (@(posedge clk) disable iff (!nrst) // [R7]
    test_sweep |-> rf_channel <= `RTM_SWEEP_LAST_CH) else $error("sweep channel out of range");
  a_sweep_code: assert property (@(posedge clk) disable iff (!nrst) // [R6]
    state_r == RTM_ST_ENTER |=> test_sweep == ($past(test_mode_select_r) == `RTM_CODE_SWEEP))
    else $error("wrong test kind");

  // A second restart while in test would let new settings in without a reset, so both are excluded.
  a_restart_once: assert property (@(posedge clk) disable iff (!nrst) // [R1]
    restart_pulse |=> !restart_pulse) else $error("restart pulse longer than one cycle");
  a_no_reentry: assert property (@(posedge clk) disable iff (!nrst) // [R2]
    test_active |-> !restart_pulse) else $error("restart while already in test");
  a_write_blocked: assert property (@(posedge clk) disable iff (!nrst) // [R4]
    (reg_wr && role_sync_r && slave_disable_r) |=> $stable(test_mode_select_r))
    else $error("test register written with slave port disabled");
  a_sweep_start: assert property (@(posedge clk) disable iff (!nrst) // [R7]
    (state_r == RTM_ST_ENTER && test_mode_select_r == `RTM_CODE_SWEEP) |=> rf_channel == 7'h00)
    else $error("sweep did not start at lowest channel");
  a_sweep_wrap: assert property (@(posedge clk) disable iff (!nrst) // [R7]
    (test_active && test_sweep && rf_channel == `RTM_SWEEP_LAST_CH && dwell_r == 32'(DWELL_CYC - 1))
    |=> rf_channel == 7'h00) else $error("sweep did not wrap after last channel");
  a_power_entry: assert property (@(posedge clk) disable iff (!nrst) // [R10]
    restart_pulse |-> rf_power_sel == `RTM_PWR_0DBM) else $error("power not 0 dBm at restart");
endmodule : rtm_test_ctrl

// file: verif/rtm_host_model.sv
// Host microcontroller model: writes the test registers and sets the force bit.
`timescale 1ns/1ps
module rtm_host_model (
  // Clock
  input  wire logic clk,
  // Slave port writes and force request
  output logic       reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       force_reconfig
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    force_reconfig = 1'b0;
  end
  // Released lines show the inverse so a stale value can never pass for a fresh one.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  // Registers written just before the call land two cycles ahead of the force request.
  task automatic frc();
    @(negedge clk);
    force_reconfig = 1'b1;
    @(negedge clk);
    force_reconfig = 1'b0;
  endtask : frc
endmodule : rtm_host_model

// file: verif/test_radio_test_mode_control.sv
// Self-checking bench for the radio test mode control block.
`timescale 1ns/1ps
`include "rtm_cfg.svh"
module test_radio_test_mode_control;
  import rtm_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, rx = 1'b0, ld_act = 1'b0, ld_done = 1'b0, ld_dis = 1'b0, dout = 1'b1;
  logic [1:0] pwr = 2'h1;
  logic       reg_wr, force_reconfig, slave_if_en, restart_pulse, test_active, test_sweep, test_tx;
  logic [7:0] reg_addr;
  rtm_byte_t  reg_wdata;
  logic [6:0] rf_channel;
  logic [1:0] rf_power_sel;
  int         n_fail = 0, tests_run = 0, cyc = 0;
  always #20 clk = ~clk;
  rtm_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .force_reconfig(force_reconfig));
  rtm_test_ctrl #(.DWELL_CYC(4)) dut (.clk(clk), .nrst(nrst), .role_receiver(rx), .eeprom_load_active(ld_act),
    .eeprom_load_done(ld_done), .eeprom_slave_disable(ld_dis), .eeprom_dout(dout), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .force_reconfig(force_reconfig), .transmit_power_setting(pwr),
    .slave_if_en(slave_if_en), .restart_pulse(restart_pulse), .test_active(test_active), .test_sweep(test_sweep),
    .test_tx(test_tx), .rf_channel(rf_channel), .rf_power_sel(rf_power_sel));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rst(input logic role);
    @(negedge clk);
    nrst = 1'b0;
    rx = role;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
  endtask : rst
  // The loader pulses done with the bit six value while dout is held as given.
  task automatic ld(input logic d, input logic dis);
    dout = d;
    repeat (3) @(negedge clk);
    ld_act = 1'b1;
    repeat (3) @(negedge clk);
    ld_done = 1'b1;
    ld_dis = dis;
    @(negedge clk);
    ld_done = 1'b0;
    ld_act = 1'b0;
    dout = 1'b1;
    @(negedge clk);
  endtask : ld
  // A hung handshake would otherwise stall the run; a few hundred cycles are expected.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    rst(1'b0);
    chk("slave_en", 8'h01, 8'(slave_if_en));
    chk("power_norm", 8'h01, 8'(rf_power_sel));
    host.frc();
    chk("no_restart", 8'h00, 8'(restart_pulse));
    host.wr(`RTM_OFS_TEST_SEL, `RTM_CODE_SINGLE);
    host.wr(`RTM_OFS_TEST_CH, 8'h85);
    host.frc();
    chk("restart", 8'h01, 8'(restart_pulse));
    chk("power_test", 8'h03, 8'(rf_power_sel));
    @(negedge clk);
    chk("active", 8'h01, 8'(test_active));
    chk("sweep_off", 8'h00, 8'(test_sweep));
    chk("tx", 8'h01, 8'(test_tx));
    chk("chan", 8'h05, 8'(rf_channel));
    host.wr(`RTM_OFS_TEST_CH, 8'h0a);
    host.frc();
    chk("no_reentry", 8'h00, 8'(restart_pulse));
    repeat (2) @(negedge clk);
    chk("hold_tx", 8'h01, 8'(test_tx));
    chk("hold_chan", 8'h05, 8'(rf_channel));
    chk("hold_power", 8'h03, 8'(rf_power_sel));
    rst(1'b1);
    chk("reset_exit", 8'h00, 8'(test_active));
    ld(1'b1, 1'b1);
    chk("slave_off", 8'h00, 8'(slave_if_en));
    host.wr(`RTM_OFS_TEST_SEL, `RTM_CODE_SINGLE);
    host.frc();
    chk("blocked", 8'h00, 8'(restart_pulse));
    rst(1'b1);
    ld(1'b0, 1'b1);
    chk("slave_on", 8'h01, 8'(slave_if_en));
    host.wr(`RTM_OFS_TEST_SEL, `RTM_CODE_SWEEP);
    host.wr(`RTM_OFS_TEST_CH, 8'h00);
    host.frc();
    repeat (2) @(negedge clk);
    chk("sweep_on", 8'h01, 8'(test_sweep));
    chk("rx", 8'h00, 8'(test_tx));
    chk("sweep_start", 8'h00, 8'(rf_channel));
    chk("power_sweep", 8'h03, 8'(rf_power_sel));
    repeat (4) @(negedge clk);
    chk("step", 8'h01, 8'(rf_channel));
    // With a dwell of 4 cycles the last channel is reached 316 cycles after the first step.
    repeat (316) @(negedge clk);
    chk("sweep_last", 8'h50, 8'(rf_channel));
    repeat (4) @(negedge clk);
    chk("sweep_wrap", 8'h00, 8'(rf_channel));
    end_sim();
  end
endmodule : test_radio_test_mode_control
